// ===== pkg/swtx_params.svh
`ifndef SWTX_PARAMS_SVH
`define SWTX_PARAMS_SVH
// Register byte offsets on APB
`define SWTX_OFF_GENCFG    12'h000
`define SWTX_OFF_PWRCFG    12'h004
`define SWTX_OFF_WAKE      12'h008
`define SWTX_OFF_BATT      12'h00c
`define SWTX_OFF_TXCFG     12'h010
`define SWTX_OFF_TXBUF     12'h014
`define SWTX_OFF_RXCFG     12'h018
`define SWTX_OFF_STATUS    12'h01c
`define SWTX_OFF_RXFIFO    12'h020
`define SWTX_OFF_CMD       12'h024
// general_config fields
`define SWTX_GEN_TXREG     7
`define SWTX_GEN_RX_FIFO_ENABLE    6
// power_mgmt_config fields
`define SWTX_PM_OSC        0
`define SWTX_PM_WUT        1
`define SWTX_PM_LBD        2
`define SWTX_PM_TXC        5
`define SWTX_PM_RXC        7
// status_word fields
`define SWTX_ST_TXRDY      15
`define SWTX_ST_WAKE       14
`define SWTX_ST_LBATT      10
`define SWTX_ST_FIFOFULL   13
`define SWTX_ST_FIFOIRQ    12
`define SWTX_ST_SLEEP      0
// Reset values
`define SWTX_PRESET_BYTE   8'haa
`define SWTX_GEN_RESET     8'h00
`define SWTX_PM_RESET      8'h01
// Wake-up duration: 1.03 ms unit and 0.5 ms offset, in ns
`define SWTX_WAKE_UNIT_NS  1030000
`define SWTX_WAKE_OFS_NS   500000
`define SWTX_CLK_NS        100
`define SWTX_WAKE_UNIT_CYC (`SWTX_WAKE_UNIT_NS / `SWTX_CLK_NS)
`define SWTX_WAKE_OFS_CYC  (`SWTX_WAKE_OFS_NS / `SWTX_CLK_NS)
`define SWTX_WAKE_EXP_MAX  5'd29
`define SWTX_FIFO_BITS     16
`endif

// ===== pkg/swtx_pkg.sv
package swtx_pkg;
   typedef enum logic [1:0] {SWTX_ACTIVE, SWTX_SLEEP} swtx_pwr_t;
   typedef enum logic [1:0] {SWTX_TX_IDLE, SWTX_TX_PRE, SWTX_TX_SEND} swtx_tx_t;
endpackage

// ===== hdl/swtx_sync.sv
// Purpose: two-flop synchroniser for pins, per bit via generate
// Assumes: inputs asynchronous to pclk
// Notes:   first stage feeds only the second
`timescale 1ns/1ns
module swtx_sync #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic stage1;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stage1      <= 1'b1;
               sync_out[i] <= 1'b1;
            end else begin
               stage1      <= async_in[i];
               sync_out[i] <= stage1;
            end
         end
      end
   endgenerate
endmodule

// ===== hdl/swtx_core.sv
// Purpose: sleep/wake control, buffered transmit register and rx fifo fill
// Assumes: pclk 10 MHz; link clock and pins sampled through swtx_sync
// Notes:   registers reached over APB, zero wait states
`timescale 1ns/1ns
`include "swtx_params.svh"
module swtx_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        link_clk,
   input  wire logic        cs_n,
   input  wire logic        serial_in,
   input  wire logic        wake_n,
   input  wire logic        shared_pin,
   input  wire logic        rx_bit,
   input  wire logic        data_valid_in,
   input  wire logic        sync_detect,
   input  wire logic        batt_below,
   output logic             host_irq_out,
   output logic             fifo_irq_out,
   output logic             serial_out,
   output logic             tx_bit_out,
   output logic             fsk_sign,
   output logic [3:0]       deviation_code,
   output logic             osc_on,
   output logic             rf_on
);
   logic [6:0] pin_s;
   swtx_sync #(.W(7)) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({link_clk, cs_n, serial_in, wake_n, shared_pin, rx_bit, data_valid_in}),
      .sync_out (pin_s)
   );
   logic lclk_s, cs_s, sdi_s, wake_s, register_select_input_s, rxb_s, dv_s;
   assign {lclk_s, cs_s, sdi_s, wake_s, register_select_input_s, rxb_s, dv_s} = pin_s;
   logic sync_det_s, batt_s;
   swtx_sync #(.W(2)) u_sync2 (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in ({sync_detect, batt_below}),
      .sync_out ({sync_det_s, batt_s})
   );

   // Registers
   logic [7:0]  general_config, power_mgmt_config, next_gen, next_pm;
   logic [12:0] wake_timer_setting, next_wts;
   logic [3:0]  lowbatt_threshold_code, next_lbc;
   logic [7:0]  tx_config, next_txc;
   logic [7:0]  rx_config, next_rxc;
   logic [7:0]  tx_byte_buffer, next_txb;
   logic        sleep_req, next_sleep_req;
   logic        lowbatt_flag, next_lbf, wake_flag, next_wake_flag;
   logic        lclk_d, next_lclk_d, cs_d, next_cs_d, wake_d, next_wake_d;
   logic [7:0]  tx_hold, tx_shift, next_tx_hold, next_tx_shift;
   logic [2:0]  tx_cnt, next_tx_cnt;
   logic        hold_full, next_hold_full, underrun, next_underrun;
   logic        byte_irq, next_byte_irq;
   swtx_pkg::swtx_tx_t  tx_st, next_tx_st;
   swtx_pkg::swtx_pwr_t pwr, next_pwr;
   logic [15:0] fifo, next_fifo;
   logic [4:0]  fifo_cnt, next_fifo_cnt;
   logic        fifo_arm, next_fifo_arm;
   logic [31:0] wake_cnt, next_wake_cnt;
   logic [7:0]  spi_sh, next_spi_sh;
   logic        spi_req, next_spi_req;
   logic [31:0] next_prdata;

   wire apb_acc = psel && penable;
   wire wr      = apb_acc && pwrite;
   // Reads are captured in the setup cycle, so the data stands at the completing edge
   wire rd      = psel && !penable && !pwrite;
   wire tx_reg_en = general_config[`SWTX_GEN_TXREG];
   wire tx_on     = power_mgmt_config[`SWTX_PM_TXC];
   wire lclk_rise = lclk_s && !lclk_d;
   wire lclk_fall = !lclk_s && lclk_d;
   wire fifo_full = fifo_cnt == 5'(`SWTX_FIFO_BITS);
   wire fifo_over = {3'h0, fifo_cnt} > rx_config;
   wire any_irq   = byte_irq || underrun || lowbatt_flag || wake_flag || fifo_over;
   wire wr_txb    = wr && paddr == `SWTX_OFF_TXBUF;

   // Wake interval in pclk cycles; exponent clamped at 29 (SWTX_WAKE_EXP_MAX)
   logic [4:0]  wexp;
   logic [63:0] wake_target;
   always_comb begin
      wexp = (wake_timer_setting[12:8] > `SWTX_WAKE_EXP_MAX) ? `SWTX_WAKE_EXP_MAX
                                                            : wake_timer_setting[12:8];
      wake_target = ((64'(`SWTX_WAKE_UNIT_CYC) * 64'(wake_timer_setting[7:0])) << wexp)
                    + 64'(`SWTX_WAKE_OFS_CYC);
   end

   always_comb begin
      next_gen = general_config;
      next_pm = power_mgmt_config;
      next_wts = wake_timer_setting;
      next_lbc = lowbatt_threshold_code;
      next_txc = tx_config;
      next_rxc = rx_config;
      next_txb = tx_byte_buffer;
      next_sleep_req = 1'b0;
      next_lbf = lowbatt_flag;
      next_wake_flag = wake_flag;
      next_lclk_d = lclk_s;
      next_cs_d = cs_s;
      next_wake_d = wake_s;
      next_prdata = prdata;
      if (wr) begin
         case (paddr)
            `SWTX_OFF_GENCFG: next_gen = pwdata[7:0];
            `SWTX_OFF_PWRCFG: next_pm  = pwdata[7:0];
            `SWTX_OFF_WAKE:   next_wts = pwdata[12:0];
            `SWTX_OFF_BATT:   next_lbc = pwdata[3:0];
            `SWTX_OFF_TXCFG:  next_txc = pwdata[7:0];
            `SWTX_OFF_TXBUF:  next_txb = pwdata[7:0];
            `SWTX_OFF_RXCFG:  next_rxc = pwdata[7:0];
            `SWTX_OFF_CMD:    next_sleep_req = pwdata[0];
            default:          next_gen = general_config;
         endcase
      end
      // Status read clears the sticky flags; a new event in that cycle wins
      if (rd && paddr == `SWTX_OFF_STATUS) begin
         next_lbf = 1'b0;
         next_wake_flag = 1'b0;
      end
      if (power_mgmt_config[`SWTX_PM_LBD] && batt_s)
         next_lbf = 1'b1;
      if ((wake_d && !wake_s) || (power_mgmt_config[`SWTX_PM_WUT]
           && 64'(wake_cnt) >= wake_target))
         next_wake_flag = 1'b1;
      if (rd) begin
         case (paddr)
            `SWTX_OFF_GENCFG: next_prdata = {24'h0, general_config};
            `SWTX_OFF_PWRCFG: next_prdata = {24'h0, power_mgmt_config};
            `SWTX_OFF_WAKE:   next_prdata = {19'h0, wake_timer_setting};
            `SWTX_OFF_BATT:   next_prdata = {28'h0, lowbatt_threshold_code};
            `SWTX_OFF_TXCFG:  next_prdata = {24'h0, tx_config};
            `SWTX_OFF_TXBUF:  next_prdata = {24'h0, tx_byte_buffer};
            `SWTX_OFF_RXCFG:  next_prdata = {24'h0, rx_config};
            `SWTX_OFF_RXFIFO: next_prdata = {16'h0, fifo};
            `SWTX_OFF_STATUS: next_prdata = {16'h0, !hold_full && tx_reg_en, wake_flag,
                                             fifo_full, fifo_over, 1'b0, lowbatt_flag,
                                             9'h0, pwr == swtx_pkg::SWTX_SLEEP};
            default:          next_prdata = 32'h0;
         endcase
      end
   end

   // Power state machine
   always_comb begin
      next_pwr = pwr;
      case (pwr)
         swtx_pkg::SWTX_ACTIVE:
            if (next_sleep_req && !any_irq)
               next_pwr = swtx_pkg::SWTX_SLEEP;
         swtx_pkg::SWTX_SLEEP:
            if (any_irq || spi_req || fifo_full || tx_on
                || power_mgmt_config[`SWTX_PM_RXC])
               next_pwr = swtx_pkg::SWTX_ACTIVE;
         default: next_pwr = swtx_pkg::SWTX_ACTIVE;
      endcase
      next_wake_cnt = power_mgmt_config[`SWTX_PM_WUT] ? wake_cnt + 32'h1 : 32'h0;
      if (next_wake_flag && !wake_flag)
         next_wake_cnt = 32'h0;
   end

   // Serial port: shifts on select low, cleared while select high
   always_comb begin
      next_spi_sh = spi_sh;
      next_spi_req = 1'b0;
      if (cs_s)
         next_spi_sh = 8'h0;
      else if (lclk_rise)
         next_spi_sh = {spi_sh[6:0], sdi_s};
      if (!cs_s && cs_d)
         next_spi_req = 1'b1;
   end

   // Transmit register
   always_comb begin
      next_tx_hold = tx_hold;
      next_tx_shift = tx_shift;
      next_tx_cnt = tx_cnt;
      next_hold_full = hold_full;
      next_underrun = underrun;
      next_byte_irq = 1'b0;
      next_tx_st = tx_st;
      case (tx_st)
         swtx_pkg::SWTX_TX_IDLE:
            if (tx_reg_en) begin
               next_tx_hold = `SWTX_PRESET_BYTE;
               next_tx_shift = `SWTX_PRESET_BYTE;
               next_hold_full = 1'b1;
               next_tx_st = swtx_pkg::SWTX_TX_PRE;
            end
         swtx_pkg::SWTX_TX_PRE:
            if (tx_on) begin
               next_tx_cnt = 3'h0;
               next_tx_st = swtx_pkg::SWTX_TX_SEND;
            end
         swtx_pkg::SWTX_TX_SEND:
            if (lclk_fall) begin
               next_tx_shift = {tx_shift[6:0], 1'b0};
               next_tx_cnt = tx_cnt + 3'h1;
               if (tx_cnt == 3'h7) begin
                  next_byte_irq = 1'b1;
                  next_underrun = !hold_full;
                  next_tx_shift = tx_hold;
                  next_hold_full = 1'b0;
               end
            end
         default: next_tx_st = swtx_pkg::SWTX_TX_IDLE;
      endcase
      if (wr_txb && tx_reg_en) begin
         next_tx_hold = pwdata[7:0];
         next_hold_full = 1'b1;
      end
      if (!tx_reg_en) begin
         next_underrun = 1'b0;
         next_tx_st = swtx_pkg::SWTX_TX_IDLE;
      end else if (!tx_on && tx_st == swtx_pkg::SWTX_TX_SEND)
         next_tx_st = swtx_pkg::SWTX_TX_PRE;
   end

   // Receive fifo
   always_comb begin
      next_fifo = fifo;
      next_fifo_cnt = fifo_cnt;
      next_fifo_arm = fifo_arm;
      if (!general_config[`SWTX_GEN_RX_FIFO_ENABLE]) begin
         next_fifo_arm = 1'b0;
         next_fifo_cnt = 5'h0;
      end else begin
         if (dv_s && sync_det_s)
            next_fifo_arm = 1'b1;
         if (fifo_arm && lclk_rise && !fifo_full) begin
            next_fifo = {fifo[14:0], rxb_s};
            next_fifo_cnt = fifo_cnt + 5'h1;
         end
         if (rd && paddr == `SWTX_OFF_RXFIFO)
            next_fifo_cnt = 5'(fifo_arm && lclk_rise && !fifo_full);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         general_config <= `SWTX_GEN_RESET;
         power_mgmt_config <= `SWTX_PM_RESET;
         wake_timer_setting <= 13'h0;
         lowbatt_threshold_code <= 4'h0;
         tx_config <= 8'h0;
         rx_config <= 8'h0;
         tx_byte_buffer <= 8'h0;
         sleep_req <= 1'b0;
         lowbatt_flag <= 1'b0;
         wake_flag <= 1'b0;
         lclk_d <= 1'b0;
         cs_d <= 1'b1;
         wake_d <= 1'b1;
         prdata <= 32'h0;
         pwr <= swtx_pkg::SWTX_ACTIVE;
         wake_cnt <= 32'h0;
         spi_sh <= 8'h0;
         spi_req <= 1'b0;
         tx_hold <= 8'h0;
         tx_shift <= 8'h0;
         tx_cnt <= 3'h0;
         hold_full <= 1'b0;
         underrun <= 1'b0;
         byte_irq <= 1'b0;
         tx_st <= swtx_pkg::SWTX_TX_IDLE;
         fifo <= 16'h0;
         fifo_cnt <= 5'h0;
         fifo_arm <= 1'b0;
      end else begin
         general_config <= next_gen;
         power_mgmt_config <= next_pm;
         wake_timer_setting <= next_wts;
         lowbatt_threshold_code <= next_lbc;
         tx_config <= next_txc;
         rx_config <= next_rxc;
         tx_byte_buffer <= next_txb;
         sleep_req <= next_sleep_req;
         lowbatt_flag <= next_lbf;
         wake_flag <= next_wake_flag;
         lclk_d <= next_lclk_d;
         cs_d <= next_cs_d;
         wake_d <= next_wake_d;
         prdata <= next_prdata;
         pwr <= next_pwr;
         wake_cnt <= next_wake_cnt;
         spi_sh <= next_spi_sh;
         spi_req <= next_spi_req;
         tx_hold <= next_tx_hold;
         tx_shift <= next_tx_shift;
         tx_cnt <= next_tx_cnt;
         hold_full <= next_hold_full;
         underrun <= next_underrun;
         byte_irq <= next_byte_irq;
         tx_st <= next_tx_st;
         fifo <= next_fifo;
         fifo_cnt <= next_fifo_cnt;
         fifo_arm <= next_fifo_arm;
      end
   end

   assign pready = 1'b1;
   assign pslverr = 1'b0;
   // Oscillator and RF off in sleep; registers above keep their contents
   assign osc_on = pwr == swtx_pkg::SWTX_ACTIVE;
   assign rf_on = osc_on && (tx_on || power_mgmt_config[`SWTX_PM_RXC]);
   // Irq high and ready low at byte end; ready means hold byte free
   assign host_irq_out = any_irq;
   assign serial_out = tx_reg_en ? (!hold_full && !byte_irq) : 1'b0;
   assign fifo_irq_out = fifo_over;
   // Pin is direct data to fsk_sign when register disabled (tx_bit_out needs SWTX_TX_SEND), ignored otherwise (tx_shift[7] used)
   wire mod_bit = tx_reg_en ? tx_shift[7] : register_select_input_s;
   assign tx_bit_out = mod_bit && tx_st == swtx_pkg::SWTX_TX_SEND;
   assign fsk_sign = tx_config[4] ^ mod_bit;
   assign deviation_code = tx_config[3:0];
endmodule

// ===== bench/swtx_core_assertions.sv
// Purpose: port-level checks on swtx_core
// Assumes: single pclk domain, pins synchronised inside the core
// Notes:   pin-driven bounds leave room for the two-flop synchroniser
`timescale 1ns/1ns
module swtx_core_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        wake_n,
   input wire logic        host_irq_out,
   input wire logic        serial_out,
   input wire logic [3:0]  deviation_code,
   input wire logic        osc_on,
   input wire logic        rf_on
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence asleep_irq;
      host_irq_out && !osc_on;
   endsequence
   sequence awake_irq;
      osc_on && host_irq_out;
   endsequence
   ready_fixed_a: assert property (pready && !pslverr)
      else $error("apb answer not zero-wait okay");
   reset_state_a: assert property ($rose(presetn) |-> osc_on && !host_irq_out && !serial_out)
      else $error("outputs wrong after reset");
   rf_gate_a: assert property (!osc_on |-> !rf_on)
      else $error("rf on while asleep");
   sleep_block_a: assert property ($fell(osc_on) |-> !$past(host_irq_out))
      else $error("sleep entered with interrupt pending");
   irq_wake_a: assert property (asleep_irq |-> ##[0:4] osc_on)
      else $error("interrupt did not wake the device");
   wake_pin_a: assert property ($fell(wake_n) && !osc_on |-> ##[1:8] awake_irq)
      else $error("wake pin pulse did not wake the device");
   dev_write_a: assert property ($changed(deviation_code) |-> $past(psel && penable && pwrite))
      else $error("deviation code moved without a write");
   rd_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
      else $error("read data moved without a read");
endmodule
bind swtx_core swtx_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wake_n(wake_n), .host_irq_out(host_irq_out), .serial_out(serial_out),
   .deviation_code(deviation_code), .osc_on(osc_on), .rf_on(rf_on));

// ===== bench/swtx_host_link.sv
// Purpose: host-side link model, clocks frames of serial and receive bits
// Assumes: a frame is requested only while the previous one has ended
// Notes:   link clock stands low between frames; idle data lines wander
`timescale 1ns/1ns
module swtx_host_link (
   input  wire logic        pclk,
   input  wire logic        start,
   input  wire logic [15:0] bits,
   input  wire logic [4:0]  len,
   output logic             link_clk,
   output logic             cs_n,
   output logic             serial_in,
   output logic             rx_bit,
   output logic             busy
);
   logic [2:0]  ph;
   logic [4:0]  left;
   logic [15:0] sh;
   initial begin
      {link_clk, serial_in, rx_bit, busy, ph, left, sh} = '0;
      cs_n = 1'b1;
   end
   // Data moves on the falling link edge, settled for the rising one
   always @(posedge pclk) begin
      if (!busy) begin
         link_clk <= 1'b0;
         cs_n <= ~start;
         serial_in <= start ? bits[15] : ~serial_in;
         rx_bit <= start ? bits[15] : ~rx_bit;
         {busy, sh, left, ph} <= {start, bits, len, 3'd0};
      end else begin
         ph <= ph + 3'd1;
         if (ph == 3'd3) link_clk <= 1'b1;
         if (ph == 3'd7) begin
            link_clk <= 1'b0;
            sh <= {sh[14:0], 1'b0};
            serial_in <= sh[14];
            rx_bit <= sh[14];
            left <= left - 5'd1;
            busy <= (left != 5'd1);
         end
      end
   end
endmodule

// ===== bench/tb.sv
// Purpose: self-checking bench for swtx_core
// Assumes: 10 MHz pclk, link clock from swtx_host_link at 800 ns
// Notes:   random deviation settings plus directed sleep, tx and fifo cases
`timescale 1ns/1ns
`include "swtx_params.svh"
module tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, v;
   logic        link_clk, cs_n, serial_in, rx_bit, wake_n, shared_pin, start, busy;
   logic        data_valid_in, sync_detect, batt_below, host_irq_out, fifo_irq_out;
   logic        serial_out, tx_bit_out, fsk_sign, osc_on, rf_on, irq_q, irq_seen, sdo_irq;
   logic        irq_arm;
   logic [3:0]  deviation_code;
   logic [15:0] fbits, txs;
   logic [4:0]  flen;
   int          bad_count, cmp_count, seed, i, n;
   swtx_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_clk(link_clk), .cs_n(cs_n), .serial_in(serial_in),
      .wake_n(wake_n), .shared_pin(shared_pin), .rx_bit(rx_bit),
      .data_valid_in(data_valid_in), .sync_detect(sync_detect), .batt_below(batt_below),
      .host_irq_out(host_irq_out), .fifo_irq_out(fifo_irq_out), .serial_out(serial_out),
      .tx_bit_out(tx_bit_out), .fsk_sign(fsk_sign), .deviation_code(deviation_code),
      .osc_on(osc_on), .rf_on(rf_on));
   swtx_host_link u_host (.pclk(pclk), .start(start), .bits(fbits), .len(flen),
      .link_clk(link_clk), .cs_n(cs_n), .serial_in(serial_in), .rx_bit(rx_bit), .busy(busy));
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      irq_q <= host_irq_out;
      if (!irq_arm)
         irq_seen <= 1'b0;
      else if (host_irq_out && !irq_q && !irq_seen) begin
         irq_seen <= 1'b1;
         sdo_irq <= serial_out;
      end
   end
   function automatic int wake_cyc(input int m, input int e);
      return `SWTX_WAKE_UNIT_CYC * m * (1 << e) + `SWTX_WAKE_OFS_CYC;
   endfunction
   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo;
      check(32'h0, 32'h1);
      results;
   endtask
   // One APB transfer; read data is taken at the edge that completes it
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (k >= 20) tmo;
      q = prdata;
      {psel, penable} <= 2'b00;
   endtask
   // Link frame; tx_bit_out sampled just before each falling link edge
   task automatic frame(input logic [15:0] b, input logic [4:0] l);
      int m;
      {start, fbits, flen} <= {1'b1, b, l};
      @(posedge pclk);
      start <= 1'b0;
      for (int k = 0; k < l; k++) begin
         // Polled link edge is seen one pclk late; two more edges reach the sample point
         for (m = 0; m < 20 && link_clk !== 1'b0; m++) @(posedge pclk);
         for (m = m; m < 40 && link_clk !== 1'b1; m++) @(posedge pclk);
         if (m >= 40) tmo;
         repeat (2) @(posedge pclk);
         txs[15-k] = tx_bit_out;
      end
      for (n = 0; n < 20 && busy; n++) @(posedge pclk);
      if (n >= 20) tmo;
      repeat (6) @(posedge pclk);
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, start, fbits, flen, irq_arm} = '0;
      {shared_pin, data_valid_in, sync_detect, batt_below} = '0;
      {bad_count, cmp_count, presetn, wake_n} = {32'h0, 32'h0, 1'b0, 1'b1};
      seed = 32'h81fd;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check({29'h0, host_irq_out, serial_out, osc_on}, 32'h1);
      check(prdata, 32'h0);
      apb(0, `SWTX_OFF_GENCFG, 0); check(q, `SWTX_GEN_RESET);
      apb(0, `SWTX_OFF_PWRCFG, 0); check(q, `SWTX_PM_RESET);
      apb(1, 12'h030, 32'hffff_ffff); apb(0, 12'h030, 0); check(q, 0);
      apb(1, `SWTX_OFF_WAKE, 32'h1dff); apb(0, `SWTX_OFF_WAKE, 0); check(q, 32'h1dff);
      apb(1, `SWTX_OFF_BATT, 32'hf); apb(0, `SWTX_OFF_BATT, 0); check(q, 32'hf);
      $display("register test done");
      for (i = 0; i < 10; i++) begin
         v = $random(seed);
         shared_pin <= v[8];
         apb(1, `SWTX_OFF_TXCFG, {27'h0, v[4:0]});
         repeat (4) @(posedge pclk);
         check(deviation_code, v[3:0]);
         check(fsk_sign, v[4] ^ v[8]);
      end
      $display("deviation test done");
      batt_below <= 1'b1;
      repeat (20) @(posedge pclk);
      check(host_irq_out, 0);
      batt_below <= 1'b0;
      apb(1, `SWTX_OFF_BATT, 32'h7); apb(1, `SWTX_OFF_PWRCFG, 32'h05);
      batt_below <= 1'b1;
      for (n = 0; n < 20 && host_irq_out !== 1'b1; n++) @(posedge pclk);
      check(host_irq_out, 1);
      apb(1, `SWTX_OFF_CMD, 1); repeat (4) @(posedge pclk);
      check(osc_on, 1);
      batt_below <= 1'b0;
      // The flag follows the comparator until its release has passed the synchroniser
      repeat (3) @(posedge pclk);
      apb(0, `SWTX_OFF_STATUS, 0); check(q[10], 1);
      apb(0, `SWTX_OFF_STATUS, 0); check({q[10], host_irq_out}, 0);
      apb(1, `SWTX_OFF_GENCFG, 0); apb(1, `SWTX_OFF_PWRCFG, 32'h01);
      $display("low battery test done");
      apb(1, `SWTX_OFF_CMD, 1); repeat (4) @(posedge pclk);
      check({osc_on, rf_on}, 0);
      apb(0, `SWTX_OFF_WAKE, 0); check(q, 32'h1dff);
      wake_n <= 1'b0;
      repeat (5) @(posedge pclk);
      wake_n <= 1'b1;
      for (n = 0; n < 20 && osc_on !== 1'b1; n++) @(posedge pclk);
      check({osc_on, host_irq_out}, 2'b11);
      apb(0, `SWTX_OFF_STATUS, 0); check(q[14], 1);
      apb(1, `SWTX_OFF_WAKE, 32'h0001); apb(1, `SWTX_OFF_PWRCFG, 32'h03);
      apb(1, `SWTX_OFF_CMD, 1); repeat (2) @(posedge pclk);
      for (n = 0; n < 20000 && osc_on !== 1'b1; n++) @(posedge pclk);
      check(n > wake_cyc(1, 0) - 60 && n < wake_cyc(1, 0) + 10, 1);
      apb(0, `SWTX_OFF_STATUS, 0); check(q[14], 1);
      apb(1, `SWTX_OFF_PWRCFG, 32'h01);
      $display("sleep and wake test done");
      irq_arm <= 1'b1;
      apb(1, `SWTX_OFF_GENCFG, 32'h80); repeat (4) @(posedge pclk);
      check(serial_out, 0);
      apb(1, `SWTX_OFF_PWRCFG, 32'h21);
      frame(16'h0, 5'd16);
      check(txs, {2{`SWTX_PRESET_BYTE}});
      check({irq_seen, sdo_irq}, 2'b10);
      check(serial_out, 1);
      apb(1, `SWTX_OFF_TXBUF, 32'h5a);
      apb(1, `SWTX_OFF_PWRCFG, 32'h01); apb(1, `SWTX_OFF_GENCFG, 0);
      repeat (4) @(posedge pclk);
      check({serial_out, host_irq_out}, 0);
      $display("transmit test done");
      apb(1, `SWTX_OFF_GENCFG, 32'h40); apb(1, `SWTX_OFF_PWRCFG, 32'h81);
      apb(1, `SWTX_OFF_RXCFG, 32'h3);
      frame(16'hffff, 5'd8);
      check(fifo_irq_out, 0);
      {data_valid_in, sync_detect} <= 2'b11;
      frame(16'hffff, 5'd3);
      check(fifo_irq_out, 0);
      frame(16'hffff, 5'd1);
      check(fifo_irq_out, 1);
      apb(0, `SWTX_OFF_STATUS, 0); check(q[15:12], 4'h1);
      apb(0, `SWTX_OFF_RXFIFO, 0); repeat (4) @(posedge pclk);
      check(fifo_irq_out, 0);
      $display("fifo test done");
      results;
   end
endmodule
